// ---- pkg/pfsc_defines.svh ----
// Constants for the program flash swap state controller.
// Included by the package and the design; definitions only.
`ifndef PFSC_DEFINES_SVH
`define PFSC_DEFINES_SVH
`define PFSC_ADDR_W 20
`define PFSC_SECT_MASK 20'hff800
`define PFSC_ST_W 3
`define PFSC_CODE_UNINIT 3'h0
`define PFSC_CODE_READY 3'h1
`define PFSC_CODE_UPDATE 3'h2
`define PFSC_CODE_UPD_ERASED 3'h3
`define PFSC_CODE_COMPLETE 3'h4
`define PFSC_CMD_W 3
`define PFSC_CMD_STATUS 3'h0
`define PFSC_CMD_INIT 3'h1
`define PFSC_CMD_UPDATE 3'h2
`define PFSC_CMD_UPD_ERASED 3'h3
`define PFSC_CMD_COMPLETE 3'h4
`define PFSC_CMD_ERASE_ALL 3'h5
`define PFSC_CMD_PROGRAM 3'h6
`define PFSC_CMD_ERASE_SECT 3'h7
`endif

// ---- pkg/pfsc_pkg.sv ----
// Types for the program flash swap state controller.
// Assumes pfsc_defines.svh is on the include path.
`include "pfsc_defines.svh"
package pfsc_pkg;
    typedef enum logic [4:0] {
        PFSC_UNINIT = 5'h01,
        PFSC_READY = 5'h02,
        PFSC_UPDATE = 5'h04,
        PFSC_UPD_ERASED = 5'h08,
        PFSC_COMPLETE = 5'h10
    } pfsc_state_t;

    typedef struct packed {
        logic valid;
        logic [`PFSC_CMD_W-1:0] code;
        logic [`PFSC_ADDR_W-1:0] addr;
        logic upper_blk;
    } pfsc_cmd_t;

    // Indicator contents as recovered from flash at reset.
    typedef struct packed {
        logic enabled;
        logic [`PFSC_ADDR_W-1:0] ind_addr;
        logic [`PFSC_ST_W-1:0] state_code;
        logic corrupted;
        logic blk_swapped;
    } pfsc_nv_t;

    typedef struct packed {
        logic done;
        logic access_error_flag;
        logic command_error_flag;
        logic [`PFSC_ST_W-1:0] state_code;
    } pfsc_status_t;

    typedef struct packed {
        pfsc_state_t state;
        logic enabled;
        logic [`PFSC_ADDR_W-1:0] ind_addr;
        logic swapped;
        logic corrupted;
        pfsc_status_t status;
        logic op_go;
    } pfsc_regs_t;
endpackage : pfsc_pkg

// ---- hdl/pfsc_ctrl.sv ----
// Swap state controller for a dual-block program flash.
// Assumes the indicator contents arrive valid in the reset cycle and that the
// program/erase engine outside acts on op_go_out and persists nv_out.
`timescale 1ns/1ps
`include "pfsc_defines.svh"

// Functional notes
// - Every reset reloads the swap state from the stored indicators: Uninitialized when not enabled, else Ready, Update or Update-Erased.
// - Corrupted indicators make the swap-status command set the command error flag.
// - Corrupted indicators still yield a valid block mapping and a full swap sequence clears them.
// - Command errors show as the access error flag in the flash status register; the command error flag only reports corruption.
// - The reset after Complete exchanges the blocks by inverting the stored swap flag, and the state is Ready.
// - Before initialisation the swap-status command reports Uninitialized.
// - Programs aimed at the indicator locations are refused.
// - Erase-all returns the swap system to Uninitialized and alone frees the indicator address.
// - The active indicator sector is never erased; the other only in Update or Update-Erased.
module pfsc_ctrl #(
    parameter int ADDR_W = `PFSC_ADDR_W,
    parameter logic [ADDR_W-1:0] SECT_MASK = `PFSC_SECT_MASK
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire pfsc_pkg::pfsc_nv_t nv_in,
    input wire pfsc_pkg::pfsc_cmd_t cmd_in,
    output pfsc_pkg::pfsc_status_t status_out,
    output pfsc_pkg::pfsc_nv_t nv_out,
    output logic op_go_out,
    output logic blk_swapped_out
);
    import pfsc_pkg::*;

    pfsc_regs_t r_q;
    pfsc_regs_t r_d;

    function automatic logic [`PFSC_ST_W-1:0] enc(input pfsc_state_t s);
        unique case (s)
            PFSC_UNINIT: enc = `PFSC_CODE_UNINIT;
            PFSC_READY: enc = `PFSC_CODE_READY;
            PFSC_UPDATE: enc = `PFSC_CODE_UPDATE;
            PFSC_UPD_ERASED: enc = `PFSC_CODE_UPD_ERASED;
            PFSC_COMPLETE: enc = `PFSC_CODE_COMPLETE;
            default: enc = `PFSC_CODE_UNINIT;
        endcase
    endfunction : enc

    function automatic pfsc_state_t dec(input logic [`PFSC_ST_W-1:0] c);
        unique case (c)
            `PFSC_CODE_UPDATE: dec = PFSC_UPDATE;
            `PFSC_CODE_UPD_ERASED: dec = PFSC_UPD_ERASED;
            `PFSC_CODE_COMPLETE: dec = PFSC_COMPLETE;
            default: dec = PFSC_READY;
        endcase
    endfunction : dec

    // Both update states open the nonactive indicator sector and may move on to Complete.
    function automatic logic in_update(input pfsc_state_t s);
        in_update = (s == PFSC_UPDATE) || (s == PFSC_UPD_ERASED);
    endfunction : in_update

    logic in_ind_sect;
    logic is_ind_word;
    logic active_sect;

    // The indicators sit at the same offset in both blocks, so only the in-block offset is matched.
    // Which block a command aims at is told apart by upper_blk alone.
    assign in_ind_sect = (cmd_in.addr & SECT_MASK) == (r_q.ind_addr & SECT_MASK);
    assign is_ind_word = cmd_in.addr == r_q.ind_addr;
    // Upper block is the nonactive one at this point of the logical map.
    assign active_sect = in_ind_sect && !cmd_in.upper_blk;

    always_comb
    begin
        r_d = r_q;
        // Pulses fall back to zero unless a command raises them in this cycle.
        r_d.op_go = 1'b0;
        r_d.status.done = 1'b0;
        if (!rstn_in)
        begin
            // Reload from indicators; corruption falls back to Ready mapping.
            r_d.enabled = nv_in.enabled;
            r_d.ind_addr = nv_in.ind_addr;
            r_d.corrupted = nv_in.enabled && nv_in.corrupted;
            r_d.swapped = nv_in.blk_swapped;
            r_d.status = '0;
            if (!nv_in.enabled)
            begin
                r_d.state = PFSC_UNINIT;
            end
            else if (nv_in.corrupted)
            begin
                r_d.state = PFSC_READY;
            end
            else if (dec(nv_in.state_code) == PFSC_COMPLETE)
            begin
                r_d.swapped = !nv_in.blk_swapped;
                r_d.state = PFSC_READY;
            end
            else
            begin
                // Unknown codes decode to Ready, so a garbled state field still boots a usable map.
                r_d.state = dec(nv_in.state_code);
            end
        end
        else if (cmd_in.valid)
        begin
            r_d.status.done = 1'b1;
            r_d.status.access_error_flag = 1'b0;
            r_d.status.command_error_flag = 1'b0;
            unique case (cmd_in.code)
                `PFSC_CMD_STATUS:
                begin
                    // The flag tells the firmware that one full swap pass must rewrite the indicators.
                    r_d.status.command_error_flag = r_q.corrupted;
                end
                `PFSC_CMD_INIT:
                begin
                    // Only taken once; after that only erase-all frees the indicator address.
                    if (r_q.state != PFSC_UNINIT)
                    begin
                        r_d.status.access_error_flag = 1'b1;
                    end
                    else
                    begin
                        r_d.enabled = 1'b1;
                        r_d.ind_addr = cmd_in.addr;
                        r_d.state = PFSC_READY;
                    end
                end
                `PFSC_CMD_UPDATE:
                begin
                    if (r_q.state == PFSC_READY)
                    begin
                        r_d.state = PFSC_UPDATE;
                    end
                    else
                    begin
                        r_d.status.access_error_flag = 1'b1;
                    end
                end
                `PFSC_CMD_UPD_ERASED:
                begin
                    if (r_q.state == PFSC_UPDATE)
                    begin
                        r_d.state = PFSC_UPD_ERASED;
                    end
                    else
                    begin
                        r_d.status.access_error_flag = 1'b1;
                    end
                end
                `PFSC_CMD_COMPLETE:
                begin
                    // Update may skip the erased step when the firmware does not report it.
                    if (in_update(r_q.state))
                    begin
                        r_d.state = PFSC_COMPLETE;
                        r_d.corrupted = 1'b0;
                    end
                    else
                    begin
                        r_d.status.access_error_flag = 1'b1;
                    end
                end
                `PFSC_CMD_ERASE_ALL:
                begin
                    // The engine wipes both blocks and the swap words, so it is started as for any erase.
                    r_d.state = PFSC_UNINIT;
                    r_d.enabled = 1'b0;
                    r_d.ind_addr = '0;
                    r_d.corrupted = 1'b0;
                    r_d.op_go = 1'b1;
                end
                `PFSC_CMD_PROGRAM:
                begin
                    // Offsets are shared, so the indicator word is refused in either block.
                    if (r_q.enabled && is_ind_word)
                    begin
                        r_d.status.access_error_flag = 1'b1;
                    end
                    else
                    begin
                        r_d.op_go = 1'b1;
                    end
                end
                `PFSC_CMD_ERASE_SECT:
                begin
                    if (r_q.enabled && in_ind_sect && (active_sect || !in_update(r_q.state)))
                    begin
                        r_d.status.access_error_flag = 1'b1;
                    end
                    else
                    begin
                        r_d.op_go = 1'b1;
                    end
                end
                default:
                begin
                    r_d.status.access_error_flag = 1'b1;
                end
            endcase
        end
        r_d.status.state_code = enc(r_d.state);
    end

    // The reset is folded into the next-state logic, so this register needs no branch of its own.
    always_ff @(posedge mclk_in)
    begin
        r_q <= r_d;
    end

    assign status_out = r_q.status;
    assign op_go_out = r_q.op_go;
    assign blk_swapped_out = r_q.swapped;
    // The image comes straight from registers, so the engine never persists a combinational glitch.
    assign nv_out.enabled = r_q.enabled;
    assign nv_out.ind_addr = r_q.ind_addr;
    assign nv_out.state_code = r_q.status.state_code;
    assign nv_out.corrupted = r_q.corrupted;
    assign nv_out.blk_swapped = r_q.swapped;
endmodule : pfsc_ctrl

// ---- verification/pfsc_ctrl_props.sv ----
// Port assertions for the swap state controller.
// Assumes the bench keeps cmd_in.valid low while in reset.
`timescale 1ns/1ps
module pfsc_ctrl_props
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire pfsc_pkg::pfsc_nv_t nv_in,
    input wire pfsc_pkg::pfsc_cmd_t cmd_in,
    input wire pfsc_pkg::pfsc_status_t status_out,
    input wire pfsc_pkg::pfsc_nv_t nv_out,
    input wire logic op_go_out,
    input wire logic blk_swapped_out
);
    import pfsc_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    a_done_follows: assert property (cmd_in.valid |=> status_out.done)
        else $error("done missing after command");
    a_done_cause: assert property (status_out.done |-> $past(cmd_in.valid))
        else $error("done without command");
    a_go_cause: assert property (op_go_out |-> $past(cmd_in.valid) && $past(cmd_in.code) >= 3'h5)
        else $error("engine start without command");
    a_refuse_nogo: assert property (status_out.access_error_flag |-> !op_go_out)
        else $error("refused operation started");
    a_init_refused: assert property (cmd_in.valid && cmd_in.code == 3'h1 && status_out.state_code != 3'h0
        |=> status_out.access_error_flag) else $error("second init accepted");
    a_wipe_uninit: assert property (cmd_in.valid && cmd_in.code == 3'h5
        |=> status_out.state_code == 3'h0 && op_go_out) else $error("erase all kept state");
    a_update_ok: assert property (cmd_in.valid && cmd_in.code == 3'h2 && status_out.state_code == 3'h1
        |=> status_out.state_code == 3'h2 && !status_out.access_error_flag) else $error("update refused");
    a_swap_reset: assert property (!$past(rstn_in) && $past(nv_in.enabled) && !$past(nv_in.corrupted)
        && $past(nv_in.state_code) == 3'h4 |-> status_out.state_code == 3'h1
        && blk_swapped_out != $past(nv_in.blk_swapped)) else $error("blocks not exchanged");
    a_flags_hold: assert property ($past(rstn_in) && !$past(cmd_in.valid)
        |-> $stable(status_out.access_error_flag)) else $error("flag moved without command");
endmodule : pfsc_ctrl_props

bind pfsc_ctrl pfsc_ctrl_props props_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .nv_in(nv_in),
    .cmd_in(cmd_in), .status_out(status_out), .nv_out(nv_out), .op_go_out(op_go_out),
    .blk_swapped_out(blk_swapped_out));

// ---- verification/pfsc_nv_store.sv ----
// Model of the stored swap indicators outside the controller.
// Assumes the controller image is final whenever reset is high.
`timescale 1ns/1ps
module pfsc_nv_store
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic preset_in,
    input wire pfsc_pkg::pfsc_nv_t preset_val_in,
    input wire pfsc_pkg::pfsc_nv_t nv_in,
    output pfsc_pkg::pfsc_nv_t nv_out
);
    import pfsc_pkg::*;
    pfsc_nv_t nv_q = '0;
    // Frozen during reset apart from a preset_in load, as the controller cannot rewrite it then.
    always_ff @(posedge mclk_in)
    begin
        if (preset_in)
            nv_q <= preset_val_in;
        else if (rstn_in)
            nv_q <= nv_in;
    end
    assign nv_out = nv_q;
endmodule : pfsc_nv_store

// ---- verification/test_pflash_swap_state_control.sv ----
// Self-checking bench for the swap state controller.
// Assumes the package, the checker and the indicator model are compiled first.
`timescale 1ns/1ps
module test_pflash_swap_state_control;
    import pfsc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pre = 1'b0;
    pfsc_nv_t pv = '0;
    pfsc_nv_t nvi;
    pfsc_nv_t nvo;
    pfsc_cmd_t c = '0;
    pfsc_status_t st;
    logic go;
    logic sw;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    pfsc_ctrl dut_u (.mclk_in(clk), .rstn_in(rstn), .nv_in(nvi), .cmd_in(c), .status_out(st),
        .nv_out(nvo), .op_go_out(go), .blk_swapped_out(sw));
    pfsc_nv_store nv_u (.mclk_in(clk), .rstn_in(rstn), .preset_in(pre), .preset_val_in(pv),
        .nv_in(nvo), .nv_out(nvi));
    task automatic conclude();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic rst(input int n);
        rstn = 1'b0;
        repeat (n) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        pre = 1'b0;
    endtask : rst
    task automatic cmd(input logic [2:0] k, input logic [19:0] a, input logic u,
        input logic [2:0] es, input logic ea, input logic eg);
        c = '{1'b1, k, a, u};
        @(negedge clk);
        c.valid = 1'b0;
        chk("done", st.done, 1'b1);
        chk("state", st.state_code, es);
        chk("acc_err", st.access_error_flag, ea);
        chk("go", go, eg);
        @(negedge clk);
        chk("done_end", st.done, 1'b0);
        chk("go_end", go, 1'b0);
    endtask : cmd
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        rst(16);
        cmd(3'h0, 20'h0, 1'b0, 3'h0, 1'b0, 1'b0);
        cmd(3'h1, 20'h3f800, 1'b0, 3'h1, 1'b0, 1'b0);
        cmd(3'h1, 20'h3f800, 1'b0, 3'h1, 1'b1, 1'b0);
        cmd(3'h7, 20'h3f800, 1'b1, 3'h1, 1'b1, 1'b0);
        cmd(3'h2, 20'h0, 1'b0, 3'h2, 1'b0, 1'b0);
        cmd(3'h6, 20'h3f800, 1'b1, 3'h2, 1'b1, 1'b0);
        cmd(3'h7, 20'h3f800, 1'b1, 3'h2, 1'b0, 1'b1);
        cmd(3'h7, 20'h3f800, 1'b0, 3'h2, 1'b1, 1'b0);
        rst(2);
        cmd(3'h0, 20'h0, 1'b0, 3'h2, 1'b0, 1'b0);
        cmd(3'h3, 20'h0, 1'b0, 3'h3, 1'b0, 1'b0);
        cmd(3'h6, 20'h01000, 1'b1, 3'h3, 1'b0, 1'b1);
        cmd(3'h4, 20'h0, 1'b0, 3'h4, 1'b0, 1'b0);
        chk("nv_state", nvo.state_code, 3'h4);
        rst(2);
        cmd(3'h0, 20'h0, 1'b0, 3'h1, 1'b0, 1'b0);
        chk("swapped", sw, 1'b1);
        pre = 1'b1;
        pv = '{1'b1, 20'h3f800, 3'h1, 1'b1, 1'b1};
        rst(2);
        cmd(3'h0, 20'h0, 1'b0, 3'h1, 1'b0, 1'b0);
        chk("cmd_err", st.command_error_flag, 1'b1);
        cmd(3'h2, 20'h0, 1'b0, 3'h2, 1'b0, 1'b0);
        cmd(3'h4, 20'h0, 1'b0, 3'h4, 1'b0, 1'b0);
        rst(2);
        cmd(3'h0, 20'h0, 1'b0, 3'h1, 1'b0, 1'b0);
        chk("cmd_err", st.command_error_flag, 1'b0);
        chk("swapped", sw, 1'b0);
        cmd(3'h5, 20'h0, 1'b0, 3'h0, 1'b0, 1'b1);
        chk("nv_enabled", nvo.enabled, 1'b0);
        cmd(3'h1, 20'h3f000, 1'b0, 3'h1, 1'b0, 1'b0);
        conclude();
    end
endmodule : test_pflash_swap_state_control
